//--- verilog/ipace_pkg.sv
package ipace_pkg;

    // ==========================================================
    // Command identification
    localparam logic [7:0] CLA_IPAUTH = 8'h80;
    localparam logic [7:0] INS_IPAUTH = 8'h80;

    // ==========================================================
    // Operation types carried in the first parameter byte
    localparam logic [7:0] OP_CHAP = 8'h00;
    localparam logic [7:0] OP_HA = 8'h01;
    localparam logic [7:0] OP_RRQ = 8'h02;
    localparam logic [7:0] OP_AAA = 8'h03;
    localparam logic [7:0] OP_AN = 8'h04;
    localparam logic [7:0] OP_MAX = 8'h04;

    // ==========================================================
    // Status word pairs
    localparam logic [7:0] SW1_OK = 8'h90;
    localparam logic [7:0] SW2_OK = 8'h00;
    localparam logic [7:0] SW1_SEQ = 8'h98;
    localparam logic [7:0] SW2_SEQ = 8'h34;
    localparam logic [7:0] SW1_BAD_P1 = 8'h6A;
    localparam logic [7:0] SW2_BAD_P1 = 8'h86;
    localparam logic [7:0] SW1_BAD_CLA = 8'h6E;
    localparam logic [7:0] SW1_BAD_INS = 8'h6D;
    localparam logic [7:0] SW1_BAD_LEN = 8'h67;
    localparam logic [7:0] SW2_NONE = 8'h00;

    // ==========================================================
    // Secret store and digest geometry
    localparam int SS_BYTES = 16;
    localparam int SS_SLOTS = 4;
    localparam int SS_BANKS = 3;
    localparam int SS_WORDS = SS_BANKS * SS_SLOTS * SS_BYTES;
    localparam logic [3:0] SS_LAST_POS = 4'hF;
    localparam logic [1:0] BANK_SIMPLE = 2'h0;
    localparam logic [1:0] BANK_HA = 2'h1;
    localparam logic [1:0] BANK_AAA = 2'h2;
    localparam logic [127:0] HASH_IV =
        128'h67452301EFCDAB8998BADCFE10325476;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
    } ipace_hdr_type;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } ipace_byte_type;

    typedef struct packed {
        logic [1:0] bank;
        logic [1:0] slot;
        logic [3:0] pos;
        logic [7:0] data;
    } ipace_ss_wr_type;

    typedef struct packed {
        logic [7:0] sw1;
        logic [7:0] sw2;
        logic has_data;
        logic [127:0] digest;
    } ipace_resp_type;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_HA = 2'b01,
        SEQ_RRQ = 2'b10
    } ipace_seq_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ID = 4'b0001,
        ST_IDX = 4'b0010,
        ST_HI = 4'b0011,
        ST_PRE = 4'b0100,
        ST_SS = 4'b0101,
        ST_MID = 4'b0110,
        ST_DATA = 4'b0111,
        ST_FIN = 4'b1000,
        ST_WAIT = 4'b1001
    } ipace_state_type;

endpackage : ipace_pkg

//--- verilog/ipace_hash.sv
`timescale 1ns/1ns
// ==========================================================
// One-way hash slot; the mixing core is meant to be swapped
module ipace_hash
    import ipace_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Byte stream in
    input wire logic start,
    input wire logic we,
    input wire logic [7:0] din,
    input wire logic fin,
    // Result
    output logic done,
    output logic [127:0] digest
);

    logic [127:0] st_r, st_nxt;
    logic done_r, done_nxt;

    always_comb begin
        st_nxt = st_r;
        done_nxt = fin;
        if (start) begin
            st_nxt = HASH_IV;
        end else if (we) begin
            st_nxt = ({st_r[119:0], st_r[127:120] ^ din})
                + {st_r[2:0], st_r[127:3]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= HASH_IV;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
    assign digest = st_r;

endmodule : ipace_hash

//--- verilog/ipace_engine.sv
`timescale 1ns/1ns
// Contract
// - Command recognised by class 80, instruction 80
// - First parameter byte selects one of five operations
// - Hash or AAA out of order answers 98 34
// - Home-agent operation may repeat without error
// - Simple CHAP returns sixteen-byte response
// - Slot index selects simple shared secret
// - Challenge of any length accepted; the code refuses an empty challenge with 67 00
// - Hash identifier, secret, challenge in order
// - Hash function replaceable, default one fitted
// - Return home-agent hash over secret and fields
// - Hash step covers supplied registration data
// - Registration hash kept, never returned
// - AAA authenticator computed and returned
// - Access-network CHAP computed and returned
module ipace_engine
    import ipace_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command header
    input wire logic cmd_valid,
    input wire ipace_hdr_type cmd_hdr,
    output logic cmd_ready,
    // Command data bytes
    input wire logic byte_valid,
    input wire ipace_byte_type byte_in,
    output logic byte_ready,
    // Secret loading
    input wire logic ss_we,
    input wire ipace_ss_wr_type ss_wr,
    // Answer
    output logic resp_valid,
    output ipace_resp_type resp
);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] ss_addr(input logic [1:0] bank,
        input logic [1:0] slot, input logic [3:0] pos);
        ss_addr = {bank, slot, pos};
    endfunction : ss_addr

    function automatic logic [1:0] bank_of(input logic [7:0] op);
        bank_of = (op == OP_HA) ? BANK_HA
            : (op == OP_AAA) ? BANK_AAA : BANK_SIMPLE;
    endfunction : bank_of

    function automatic ipace_resp_type mk_resp(input logic [7:0] s1,
        input logic [7:0] s2, input logic hd, input logic [127:0] dg);
        mk_resp = '{sw1: s1, sw2: s2, has_data: hd, digest: dg};
    endfunction : mk_resp

    // ==========================================================
    // Secret store; no reset, contents are loaded by software
    logic [7:0] ss_mem [0:SS_WORDS-1];

    always_ff @(posedge clk) begin
        if (ss_we && ss_wr.bank <= BANK_AAA) begin
            ss_mem[ss_addr(ss_wr.bank, ss_wr.slot, ss_wr.pos)]
                <= ss_wr.data;
        end
    end

    // ==========================================================
    // Control state
    ipace_state_type state_r, state_nxt;
    ipace_seq_type seq_r, seq_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] id_r, id_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic tail_r, tail_nxt;
    logic [127:0] rrq_r, rrq_nxt;
    logic h_start_r, h_start_nxt;
    logic h_we_r, h_we_nxt;
    logic [7:0] h_din_r, h_din_nxt;
    logic h_fin_r, h_fin_nxt;
    logic cmd_ready_r, cmd_ready_nxt;
    logic byte_ready_r, byte_ready_nxt;
    logic resp_valid_r, resp_valid_nxt;
    ipace_resp_type resp_r, resp_nxt;
    logic h_done;
    logic [127:0] h_digest;
    logic take;

    // Default hash core; an operator core drops in here
    ipace_hash u_hash (
        .clk(clk),
        .resetn(resetn),
        .start(h_start_r),
        .we(h_we_r),
        .din(h_din_r),
        .fin(h_fin_r),
        .done(h_done),
        .digest(h_digest)
    );

    assign take = byte_valid && byte_ready_r;

    always_comb begin
        state_nxt = state_r;
        seq_nxt = seq_r;
        op_nxt = op_r;
        id_nxt = id_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        tail_nxt = tail_r;
        rrq_nxt = rrq_r;
        h_start_nxt = 1'b0;
        h_we_nxt = 1'b0;
        h_din_nxt = h_din_r;
        h_fin_nxt = 1'b0;
        resp_valid_nxt = 1'b0;
        resp_nxt = resp_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_valid) begin
                    op_nxt = cmd_hdr.p1;
                    idx_nxt = 2'h0;
                    tail_nxt = 1'b0;
                    resp_valid_nxt = 1'b1;
                    if (cmd_hdr.cla != CLA_IPAUTH) begin
                        resp_nxt = mk_resp(SW1_BAD_CLA, SW2_NONE, 1'b0,
                            '0);
                    end else if (cmd_hdr.ins != INS_IPAUTH) begin
                        resp_nxt = mk_resp(SW1_BAD_INS, SW2_NONE, 1'b0,
                            '0);
                    end else if (cmd_hdr.p1 > OP_MAX) begin
                        resp_nxt = mk_resp(SW1_BAD_P1, SW2_BAD_P1, 1'b0,
                            '0);
                    end else if ((cmd_hdr.p1 == OP_RRQ
                        && seq_r == SEQ_IDLE) || (cmd_hdr.p1 == OP_AAA
                        && seq_r != SEQ_RRQ)) begin
                        resp_nxt = mk_resp(SW1_SEQ, SW2_SEQ, 1'b0, '0);
                    end else begin
                        resp_valid_nxt = 1'b0;
                        h_start_nxt = 1'b1;
                        case (cmd_hdr.p1)
                            OP_CHAP, OP_AN: state_nxt = ST_ID;
                            OP_HA, OP_AAA: state_nxt = ST_IDX;
                            default: state_nxt = ST_DATA;
                        endcase
                    end
                end
            end
            ST_ID, ST_IDX, ST_HI: begin
                if (take && byte_in.last) begin
                    // Too short to hold the leading fields and one data byte
                    state_nxt = ST_IDLE;
                    resp_valid_nxt = 1'b1;
                    resp_nxt = mk_resp(SW1_BAD_LEN, SW2_NONE, 1'b0, '0);
                end else if (take) begin
                    cnt_nxt = 4'h0;
                    if (state_r == ST_IDX) begin
                        idx_nxt = byte_in.data[1:0];
                        state_nxt = (op_r == OP_AAA) ? ST_HI
                            : (op_r == OP_CHAP) ? ST_PRE : ST_SS;
                    end else begin
                        id_nxt = byte_in.data;
                        state_nxt = (op_r == OP_CHAP) ? ST_IDX : ST_PRE;
                    end
                end
            end
            ST_PRE: begin
                h_we_nxt = 1'b1;
                h_din_nxt = id_r;
                cnt_nxt = 4'h0;
                state_nxt = ST_SS;
            end
            ST_SS: begin
                h_we_nxt = 1'b1;
                h_din_nxt = ss_mem[ss_addr(bank_of(op_r), idx_r, cnt_r)];
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == SS_LAST_POS) begin
                    state_nxt = (op_r == OP_AAA) ? ST_MID
                        : tail_r ? ST_FIN : ST_DATA;
                end
            end
            ST_MID: begin
                h_we_nxt = 1'b1;
                h_din_nxt = rrq_r[127 - 8*cnt_r -: 8];
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == SS_LAST_POS) begin
                    state_nxt = ST_DATA;
                end
            end
            ST_DATA: begin
                if (take) begin
                    h_we_nxt = 1'b1;
                    h_din_nxt = byte_in.data;
                    if (byte_in.last) begin
                        cnt_nxt = 4'h0;
                        tail_nxt = (op_r == OP_HA);
                        state_nxt = (op_r == OP_HA) ? ST_SS : ST_FIN;
                    end
                end
            end
            ST_FIN: begin
                h_fin_nxt = 1'b1;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (h_done) begin
                    state_nxt = ST_IDLE;
                    tail_nxt = 1'b0;
                    resp_valid_nxt = 1'b1;
                    if (op_r == OP_RRQ) begin
                        rrq_nxt = h_digest;
                        seq_nxt = SEQ_RRQ;
                        resp_nxt = mk_resp(SW1_OK, SW2_OK, 1'b0, '0);
                    end else begin
                        resp_nxt = mk_resp(SW1_OK, SW2_OK, 1'b1,
                            h_digest);
                        if (op_r == OP_HA) begin
                            seq_nxt = SEQ_HA;
                        end else if (op_r == OP_AAA) begin
                            seq_nxt = SEQ_IDLE;
                            rrq_nxt = '0;
                        end
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        cmd_ready_nxt = (state_nxt == ST_IDLE);
        byte_ready_nxt = (state_nxt == ST_ID) || (state_nxt == ST_IDX)
            || (state_nxt == ST_HI) || (state_nxt == ST_DATA);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            seq_r <= SEQ_IDLE;
            op_r <= 8'h00;
            id_r <= 8'h00;
            idx_r <= 2'h0;
            cnt_r <= 4'h0;
            tail_r <= 1'b0;
            rrq_r <= '0;
            h_start_r <= 1'b0;
            h_we_r <= 1'b0;
            h_din_r <= 8'h00;
            h_fin_r <= 1'b0;
            cmd_ready_r <= 1'b1;
            byte_ready_r <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_r <= '0;
        end else begin
            state_r <= state_nxt;
            seq_r <= seq_nxt;
            op_r <= op_nxt;
            id_r <= id_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            tail_r <= tail_nxt;
            rrq_r <= rrq_nxt;
            h_start_r <= h_start_nxt;
            h_we_r <= h_we_nxt;
            h_din_r <= h_din_nxt;
            h_fin_r <= h_fin_nxt;
            cmd_ready_r <= cmd_ready_nxt;
            byte_ready_r <= byte_ready_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_r <= resp_nxt;
        end
    end

    assign cmd_ready = cmd_ready_r;
    assign byte_ready = byte_ready_r;
    assign resp_valid = resp_valid_r;
    assign resp = resp_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic hdr_ok;
    assign hdr_ok = cmd_hdr.cla == CLA_IPAUTH
        && cmd_hdr.ins == INS_IPAUTH;

    class_check_a: assert property (state_r == ST_IDLE && cmd_valid
        && cmd_hdr.cla != CLA_IPAUTH |=> resp_valid_r
        && resp_r.sw1 == SW1_BAD_CLA)
        else $error("bad class not refused");
    op_range_a: assert property (state_r == ST_IDLE && cmd_valid
        && hdr_ok && cmd_hdr.p1 > OP_MAX |=> resp_valid_r
        && resp_r.sw2 == SW2_BAD_P1 && !h_start_r)
        else $error("bad operation type not refused");
    seq_error_a: assert property (state_r == ST_IDLE && cmd_valid
        && hdr_ok && cmd_hdr.p1 == OP_AAA && seq_r != SEQ_RRQ
        |=> resp_valid_r && resp_r.sw1 == SW1_SEQ
        && resp_r.sw2 == SW2_SEQ)
        else $error("out of order AAA not refused");
    ha_repeat_a: assert property (state_r == ST_IDLE && cmd_valid
        && hdr_ok && cmd_hdr.p1 == OP_HA |=> state_r == ST_IDX
        && !resp_valid_r)
        else $error("home-agent repeat refused");
    hash_kept_a: assert property (resp_valid_r && op_r == OP_RRQ
        && resp_r.sw1 == SW1_OK |-> !resp_r.has_data
        && seq_r == SEQ_RRQ)
        else $error("registration hash leaked or lost");
    aaa_clear_a: assert property (resp_valid_r && op_r == OP_AAA
        && resp_r.sw1 == SW1_OK |-> seq_r == SEQ_IDLE && rrq_r == '0)
        else $error("sequence not cleared after AAA");
    chap_len_a: assert property (resp_valid_r && op_r == OP_CHAP
        && resp_r.sw1 == SW1_OK |-> resp_r.has_data
        && $past(state_r) == ST_WAIT)
        else $error("CHAP answer without digest");
    secret_feed_a: assert property ($rose(state_r == ST_SS)
        |-> (state_r == ST_SS)[*8] ##1 (state_r == ST_SS)[*8]
        ##1 state_r != ST_SS)
        else $error("secret not fed sixteen bytes");
    data_ready_a: assert property (state_r == ST_DATA && take
        && !byte_in.last |=> state_r == ST_DATA && byte_ready_r)
        else $error("challenge cut short");

    chap_done_c: cover property (resp_valid_r && op_r == OP_CHAP
        && resp_r.has_data);
    aaa_done_c: cover property (resp_valid_r && op_r == OP_AAA
        && resp_r.has_data);
    seq_err_c: cover property (resp_valid_r && resp_r.sw1 == SW1_SEQ);
    an_done_c: cover property (resp_valid_r && op_r == OP_AN
        && resp_r.has_data);

endmodule : ipace_engine

//--- tb/ipace_host.sv
`timescale 1ns/1ns
module ipace_host
    import ipace_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command
    output logic cmd_valid,
    output ipace_hdr_type cmd_hdr,
    input wire logic cmd_ready,
    // Data
    output logic byte_valid,
    output ipace_byte_type byte_in,
    input wire logic byte_ready,
    // Answer
    input wire logic resp_valid,
    input wire ipace_resp_type resp
);
    logic [7:0] dat [0:39];

    initial begin
        cmd_valid = 1'b0;
        cmd_hdr = '0;
        byte_valid = 1'b0;
        byte_in = '0;
    end

    // ==================================================
    // Frame sender; gap idles between bytes make a slow host
    task automatic send(input logic [7:0] cla, input logic [7:0] ins,
        input logic [7:0] p1, input int n, input int gap,
        output ipace_resp_type r, output logic ok);
        int i;
        int g;
        logic cv;
        logic bv;
        i = 0;
        g = 0;
        cv = 1'b1;
        bv = 1'b0;
        ok = 1'b0;
        @(posedge clk);
        cmd_hdr <= '{cla, ins, p1, 8'h00, n[7:0]};
        cmd_valid <= 1'b1;
        for (int k = 0; k < 600 && !ok; k++) begin
            @(posedge clk);
            if (resp_valid === 1'b1) begin
                r = resp;
                ok = 1'b1;
            end else begin
                if (cv && cmd_ready === 1'b1) begin
                    cv = 1'b0;
                    cmd_valid <= 1'b0;
                end
                if (bv && byte_ready === 1'b1) begin
                    i++;
                    bv = 1'b0;
                    g = 0;
                end
                if (!bv) begin
                    g++;
                end
                if (!cv && !bv && i < n && g > gap) begin
                    bv = 1'b1;
                end
                // Idle lines toggle so a stale byte never looks valid
                byte_valid <= bv;
                byte_in <= bv ? ipace_byte_type'{dat[i], i == n - 1}
                    : ipace_byte_type'(~byte_in);
            end
        end
        if (ok) begin
            byte_valid <= 1'b0;
        end
    endtask : send
endmodule : ipace_host

//--- tb/ipace_engine_bench.sv
`timescale 1ns/1ns
module ipace_engine_bench
    import ipace_pkg::*;
;
    localparam logic [15:0] SW_OK = {SW1_OK, SW2_OK};
    localparam logic [15:0] SW_SEQ = {SW1_SEQ, SW2_SEQ};
    localparam logic [15:0] SW_CLA = {SW1_BAD_CLA, SW2_NONE};
    localparam logic [15:0] SW_INS = {SW1_BAD_INS, SW2_NONE};
    logic clk;
    logic resetn;
    logic cmd_valid;
    ipace_hdr_type cmd_hdr;
    logic cmd_ready;
    logic byte_valid;
    ipace_byte_type byte_in;
    logic byte_ready;
    logic ss_we;
    ipace_ss_wr_type ss_wr;
    logic resp_valid;
    ipace_resp_type resp;
    ipace_resp_type r;
    int fail_count;
    int n_tests;
    logic [127:0] d [0:2];

    ipace_engine u_ipace_engine (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr), .cmd_ready(cmd_ready),
        .byte_valid(byte_valid), .byte_in(byte_in),
        .byte_ready(byte_ready), .ss_we(ss_we), .ss_wr(ss_wr),
        .resp_valid(resp_valid), .resp(resp));

    ipace_host u_ipace_host (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_hdr(cmd_hdr), .cmd_ready(cmd_ready),
        .byte_valid(byte_valid), .byte_in(byte_in),
        .byte_ready(byte_ready), .resp_valid(resp_valid), .resp(resp));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==================================================
    // Shared tasks
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic cmp(input string nm, input logic [127:0] a,
        input logic [127:0] b, input logic eq);
        n_tests++;
        if ((a === b) !== eq) begin
            fail_count++;
            $display("Error %s expected equal=%b seen %h", nm, eq, b);
        end
    endtask : cmp

    task automatic run(input logic [7:0] cla, input logic [7:0] ins,
        input logic [7:0] p1, input int n, input int gap,
        input logic [15:0] sw, input logic hd);
        logic ok;
        u_ipace_host.send(cla, ins, p1, n, gap, r, ok);
        if (!ok) begin
            fail_count++;
            $display("Error answer expected within bound seen none");
            summarize();
        end else begin
            check("status", sw, {r.sw1, r.sw2});
            if (sw == SW_OK) begin
                check("has_data", {15'h0, hd}, {15'h0, r.has_data});
            end
        end
    endtask : run

    task automatic op(input logic [7:0] p1, input int n, input int gap,
        input logic [15:0] sw, input logic hd);
        run(CLA_IPAUTH, INS_IPAUTH, p1, n, gap, sw, hd);
    endtask : op

    task automatic fill(input logic [7:0] seed, input int n);
        for (int i = 0; i < n; i++) begin
            u_ipace_host.dat[i] = seed + i[7:0];
        end
    endtask : fill

    task automatic load_ss;
        for (int k = 0; k < SS_WORDS; k++) begin
            @(posedge clk);
            ss_we <= 1'b1;
            ss_wr <= '{k[7:6], k[5:4], k[3:0], k[7:0] ^ 8'h3C};
        end
        @(posedge clk);
        ss_we <= 1'b0;
    endtask : load_ss

    // ==================================================
    // Scenarios
    task automatic t_reset;
        // First edge applies reset even if the time-zero fall was missed
        @(posedge clk);
        @(negedge clk);
        check("idle ready", 16'h0002, {14'h0, cmd_ready, byte_ready});
        check("idle answer", 16'h0000, {15'h0, resp_valid});
        check("idle status", 16'h0000, {resp.sw1, resp.sw2});
        $display("Test reset done");
    endtask : t_reset

    task automatic t_header;
        fill(8'h11, 3);
        run(8'h00, INS_IPAUTH, OP_CHAP, 3, 0, SW_CLA, 0);
        run(CLA_IPAUTH, 8'hA0, OP_CHAP, 3, 0, SW_INS, 0);
        op(8'h05, 3, 0, {SW1_BAD_P1, SW2_BAD_P1}, 0);
        op(8'hFF, 3, 0, {SW1_BAD_P1, SW2_BAD_P1}, 0);
        $display("Test header done");
    endtask : t_header

    task automatic t_mip;
        fill(8'h40, 6);
        op(OP_RRQ, 6, 0, SW_SEQ, 0);
        op(OP_AAA, 4, 0, SW_SEQ, 0);
        op(OP_HA, 6, 0, SW_OK, 1);
        d[0] = r.digest;
        op(OP_HA, 6, 1, SW_OK, 1);
        cmp("repeat ha", d[0], r.digest, 1);
        u_ipace_host.dat[0] = 8'h02;
        op(OP_HA, 6, 0, SW_OK, 1);
        cmp("ha slot", d[0], r.digest, 0);
        op(OP_RRQ, 6, 0, SW_OK, 0);
        cmp("rrq digest", 128'h0, r.digest, 1);
        op(OP_AAA, 4, 0, SW_OK, 1);
        d[1] = r.digest;
        op(OP_AAA, 4, 0, SW_SEQ, 0);
        op(OP_RRQ, 6, 0, SW_SEQ, 0);
        op(OP_HA, 6, 0, SW_OK, 1);
        u_ipace_host.dat[5] = 8'hEE;
        op(OP_RRQ, 6, 2, SW_OK, 0);
        op(OP_AAA, 4, 0, SW_OK, 1);
        cmp("aaa uses hash", d[1], r.digest, 0);
        $display("Test mobile done");
    endtask : t_mip

    task automatic t_chap;
        fill(8'h20, 3);
        u_ipace_host.dat[1] = 8'h00;
        op(OP_CHAP, 3, 0, SW_OK, 1);
        d[2] = r.digest;
        u_ipace_host.dat[1] = 8'h01;
        op(OP_CHAP, 3, 0, SW_OK, 1);
        cmp("chap slot", d[2], r.digest, 0);
        u_ipace_host.dat[1] = 8'h00;
        u_ipace_host.dat[0] = 8'h21;
        op(OP_CHAP, 3, 0, SW_OK, 1);
        cmp("chap id", d[2], r.digest, 0);
        u_ipace_host.dat[0] = 8'h20;
        u_ipace_host.dat[1] = 8'h22;
        op(OP_AN, 2, 0, SW_OK, 1);
        cmp("an digest", d[2], r.digest, 1);
        fill(8'h30, 24);
        op(OP_CHAP, 24, 2, SW_OK, 1);
        op(OP_CHAP, 2, 0, {SW1_BAD_LEN, SW2_NONE}, 0);
        $display("Test chap done");
    endtask : t_chap

    initial begin
        resetn = 1'b0;
        ss_we = 1'b0;
        ss_wr = '0;
        fail_count = 0;
        n_tests = 0;
        t_reset();
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        load_ss();
        t_header();
        t_mip();
        t_chap();
        summarize();
    end
endmodule : ipace_engine_bench
